/* verif/sgf_host.sv */
// Host model on the register port: one-cycle strobes, read data
// taken in the slot after the read strobe. Assumes one clock.
`timescale 1ns/1ps

module sgf_host
   import sgf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic [31:0] regRdData,
   output logic      [7:0]  regAddr,
   output logic      [31:0] regWrData,
   output logic             regWr,
   output logic             regRd
);
   initial begin
      regAddr   = 8'h00;
      regWrData = 32'h0000_0000;
      regWr     = 1'b0;
      regRd     = 1'b0;
   end

   // Restart after a short is always a disable then enable pair
   // Open-load flags are read only while the motor steps slowly
   // Released lines show the inverse, never the stale value
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr     <= 1'b0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd   <= 1'b0;
      regAddr <= ~a;
      @(negedge core_clk);
      d = regRdData;
   endtask
endmodule

/* verif/sgf_step_fault_core_properties.sv */
// Port-level checks of the step and fault core.
// Assumes one clock domain; bound from the testbench top.
`timescale 1ns/1ps

module sgf_props
   import sgf_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   input wire logic        tempShutdownIn,
   input wire logic [3:0]  shortDetIn,
   input wire logic        bridgeEnable,
   input wire logic        stepOut,
   input wire logic        stepDirOut,
   input wire logic [9:0]  msPosition
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_read_idle: assert property (!regRd |=> regRdData == 32'h0000_0000)
      else $error("read data outside its slot");
   chk_pos_hold: assert property (!stepOut |-> $stable(msPosition))
      else $error("position moved without a step");
   chk_pos_up: assert property (stepOut && !stepDirOut |->
      10'(msPosition - $past(msPosition)) inside {1, 2, 4, 8, 16, 32, 64, 128, 256})
      else $error("bad upward position step");
   chk_pos_down: assert property (stepOut && stepDirOut |->
      10'($past(msPosition) - msPosition) inside {1, 2, 4, 8, 16, 32, 64, 128, 256})
      else $error("bad downward position step");
   chk_step_gap: assert property (stepOut |=> !stepOut)
      else $error("steps faster than half the clock");
   chk_ot_off: assert property (tempShutdownIn [*4] |=> !bridgeEnable)
      else $error("bridges on during shutdown temperature");
   chk_ot_release: assert property ($rose(bridgeEnable) |-> !$past(tempShutdownIn, 4))
      else $error("bridges back on while hot");
   chk_short_pause: assert property ((bridgeEnable && shortDetIn != 4'h0) [*4]
      |=> !bridgeEnable)
      else $error("bridges kept on through a short");
endmodule

/* verif/testbench.sv */
// Self-checking bench of the step and fault core.
// Assumes the host model owns the register port.
`timescale 1ns/1ps

module testbench;
   import sgf_pkg::*;
   // Quiet window longer than one retry pause so hits accumulate
   localparam int QUIET = 300;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  regAddr;
   logic [31:0] regWrData, regRdData, rdv;
   logic        regWr, regRd, bridgeEnable, stepOut, stepDirOut, diagOut, irq;
   logic        stepIn = 1'b0, dirIn = 1'b0, tempPreWarnIn = 1'b0, tempShutdownIn = 1'b0;
   logic [3:0]  shortDetIn = 4'h0;
   logic [1:0]  openLoadIn = 2'h0;
   logic [9:0]  msPosition;
   int          n_mismatch = 0, n_tests = 0, ns, nd;

   always #4 core_clk = ~core_clk;

   sgf_host host_i (.core_clk(core_clk), .regRdData(regRdData), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd));
   sgf_step_fault_core #(.SHORT_QUIET_CYC(QUIET)) sgf_step_fault_core_i (
      .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .stepIn(stepIn),
      .dirIn(dirIn), .tempPreWarnIn(tempPreWarnIn), .tempShutdownIn(tempShutdownIn),
      .shortDetIn(shortDetIn), .openLoadIn(openLoadIn), .bridgeEnable(bridgeEnable),
      .stepOut(stepOut), .stepDirOut(stepDirOut), .msPosition(msPosition),
      .diagOut(diagOut), .irq(irq));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      host_i.rd(a, rdv);
      check(what, rdv, exp);
   endtask

   task automatic check_pin(input string what, input logic seen, input logic exp);
      check(what, {31'h0, seen}, {31'h0, exp});
   endtask

   // Bounded wait; running out shows up as a mismatch
   task automatic wait_bridge(input logic exp, input int lim);
      int k;
      k = 0;
      while (bridgeEnable !== exp && k < lim) begin
         @(negedge core_clk);
         k++;
      end
      check_pin("bridgeEnable", bridgeEnable, exp);
      if (bridgeEnable !== exp) begin
         final_report();
      end
   endtask

   // Pulse widths well above the synchroniser depth
   task automatic ext_step(input logic d);
      @(posedge core_clk);
      dirIn <= d;
      repeat (3) @(posedge core_clk);
      stepIn <= 1'b1;
      repeat (4) @(posedge core_clk);
      stepIn <= 1'b0;
      repeat (5) @(posedge core_clk);
   endtask

   task automatic count_steps(input int cyc);
      logic prev;
      ns = 0;
      nd = 0;
      prev = diagOut;
      repeat (cyc) begin
         @(negedge core_clk);
         ns += int'(stepOut === 1'b1);
         nd += int'(diagOut !== prev);
         prev = diagOut;
      end
   endtask

   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(REG_STEP_INTERVAL, 32'h000F_FFFF, "interval at reset");
      rd_chk(REG_MSTEP_POSITION, 32'h0000_0000, "position at reset");
      rd_chk(8'h20, 32'h0000_0000, "unmapped read");
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0041);
      wait_bridge(1'b1, 20);
      ext_step(1'b1);
      rd_chk(REG_MSTEP_POSITION, 32'h0000_0300, "wrap below zero");
      check("msPosition", 32'(msPosition), 32'h0000_0300);
      ext_step(1'b0);
      rd_chk(REG_MSTEP_POSITION, 32'h0000_0000, "wrap above top");
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0043);
      repeat (3) @(posedge core_clk);
      check_pin("index at zero", diagOut, 1'b1);
      ext_step(1'b0);
      check_pin("index off zero", diagOut, 1'b0);
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0003);
      ext_step(1'b1);
      rd_chk(REG_MSTEP_POSITION, 32'h0000_00FF, "fine step down");
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0000);
      ext_step(1'b1);
      rd_chk(REG_MSTEP_POSITION, 32'h0000_00FF, "step while disabled");
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0005);
      host_i.wr(REG_VELOCITY, 32'h0040_0000);
      repeat (10) @(posedge core_clk);
      count_steps(400);
      check("internal steps", 32'(ns), 32'h0000_0064);
      check("diag toggles", 32'(nd), 32'h0000_0064);
      rd_chk(REG_STEP_INTERVAL, 32'h0000_0004, "interval");
      host_i.wr(REG_VELOCITY, 32'h00C0_0000);
      repeat (10) @(posedge core_clk);
      count_steps(400);
      check("reverse steps", 32'(ns), 32'h0000_0064);
      check_pin("reverse dir", stepDirOut, 1'b1);
      host_i.wr(REG_VELOCITY, 32'h0000_0000);
      repeat (8) @(posedge core_clk);
      count_steps(100);
      check("steps at zero", 32'(ns), 32'h0000_0000);
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0001);
      host_i.wr(REG_IRQ_CLEAR, 32'h0000_003F);
      host_i.wr(REG_IRQ_ENABLE, 32'h0000_0000);
      @(posedge core_clk);
      tempPreWarnIn  <= 1'b1;
      tempShutdownIn <= 1'b1;
      wait_bridge(1'b0, 10);
      rd_chk(REG_FAULT_STATUS, 32'h0000_0003, "hot flags");
      check_pin("fault pin", diagOut, 1'b1);
      check_pin("masked irq", irq, 1'b0);
      host_i.wr(REG_IRQ_ENABLE, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      check_pin("irq", irq, 1'b1);
      tempShutdownIn <= 1'b0;
      repeat (20) @(posedge core_clk);
      check_pin("bridge while warm", bridgeEnable, 1'b0);
      host_i.wr(REG_IRQ_CLEAR, 32'h0000_003F);
      repeat (2) @(posedge core_clk);
      check_pin("irq cleared", irq, 1'b0);
      tempPreWarnIn <= 1'b0;
      wait_bridge(1'b1, 10);
      host_i.wr(REG_IRQ_ENABLE, 32'h0000_0004);
      @(posedge core_clk);
      shortDetIn <= 4'h2;
      repeat (60) @(posedge core_clk);
      host_i.rd(REG_FAULT_STATUS, rdv);
      check("flags after one hit", rdv & 32'h0000_003C, 32'h0000_0000);
      repeat (700) @(posedge core_clk);
      shortDetIn <= 4'h0;
      repeat (QUIET + 50) @(posedge core_clk);
      rd_chk(REG_FAULT_STATUS, 32'h0000_0008, "short latched");
      check_pin("short irq", irq, 1'b1);
      check_pin("short pin", diagOut, 1'b1);
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0000);
      host_i.wr(REG_GLOBAL_CONFIG, 32'h0000_0001);
      wait_bridge(1'b1, 10);
      rd_chk(REG_FAULT_STATUS, 32'h0000_0100, "short cleared");
      host_i.wr(REG_VELOCITY, 32'h0000_1000);
      @(posedge core_clk);
      openLoadIn <= 2'h1;
      repeat (8) @(posedge core_clk);
      rd_chk(REG_FAULT_STATUS, 32'h0000_0140, "open load");
      check_pin("bridge with open load", bridgeEnable, 1'b1);
      final_report();
   end
endmodule

bind sgf_step_fault_core sgf_props sgf_props_i (
   .core_clk(core_clk), .rst(rst), .regRd(regRd), .regRdData(regRdData),
   .tempShutdownIn(tempShutdownIn), .shortDetIn(shortDetIn),
   .bridgeEnable(bridgeEnable), .stepOut(stepOut), .stepDirOut(stepDirOut),
   .msPosition(msPosition));

/* verilog/sgf_pkg.sv */
// Package of the step generator and fault flag core: register map,
// field layouts, reset values and timing counts.
// Assumes a single 125 MHz core clock.
package sgf_pkg;

   // ------------------------------------------------------------------
   // Register map (byte offsets)
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_GLOBAL_CONFIG  = 8'h00;
   localparam logic [7:0] REG_VELOCITY       = 8'h04;
   localparam logic [7:0] REG_STEP_INTERVAL  = 8'h08;
   localparam logic [7:0] REG_MSTEP_POSITION = 8'h0C;
   localparam logic [7:0] REG_FAULT_STATUS   = 8'h10;
   localparam logic [7:0] REG_IRQ_STATUS     = 8'h14;
   localparam logic [7:0] REG_IRQ_CLEAR      = 8'h18;
   localparam logic [7:0] REG_IRQ_ENABLE     = 8'h1C;

   // ------------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] resSel;     // Bits 6:3, log2 of microstep step width
      logic       diagStep;   // Bit 2
      logic       diagIndex;  // Bit 1
      logic       drvEnable;  // Bit 0
   } sgf_cfg_type;

   typedef struct packed {
      logic       bridgeOn;   // Bit 8
      logic [1:0] openLoad;   // Bits 7:6, coil B, coil A
      logic [3:0] shortFlag;  // Bits 5:2, supply B, supply A, ground B, ground A
      logic       overTemp;   // Bit 1
      logic       preWarn;    // Bit 0
   } sgf_fault_type;

   localparam int          IRQ_W           = 6;
   localparam int          IRQ_PREWARN     = 0;
   localparam int          IRQ_OVERTEMP    = 1;
   localparam int          IRQ_SHORT       = 2;
   localparam int          IRQ_OPEN_A      = 3;
   localparam int          IRQ_OPEN_B      = 4;
   localparam int          IRQ_INDEX       = 5;

   localparam sgf_cfg_type CFG_RESET       = 7'h00;
   localparam logic [23:0] VELOCITY_RESET  = 24'h00_0000;
   localparam logic [3:0]  RES_SEL_MAX     = 4'h8;
   localparam logic [19:0] INTERVAL_MAX    = 20'hF_FFFF;
   localparam logic [1:0]  SHORT_RETRIES   = 2'h3;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 8;
   localparam int          CLK_MHZ         = 125;
   localparam int          RETRY_BLANK_NS  = 1000;
   localparam logic [7:0]  RETRY_BLANK_CYC =
      8'((RETRY_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int          SHORT_QUIET_US  = 100;

endpackage

/* verilog/sgf_step_fault_core.sv */
// Step generation, microstep position, step interval and protection
// flags of a two-phase stepper driver, with a simple register port.
// Assumes analog detector and step/dir inputs are asynchronous levels.
`timescale 1ns/1ps

// Functional notes
// - Internal generator steps at a constant rate, no ramp of its own.
// - Signed velocity; rate is magnitude times clock over 2^24, sign is direction.
// - Interval measure reports clock cycles per executed microstep.
// - Step indication mode toggles the status pin on every microstep.
// - Position counter is readable and wraps modulo 1024 both ways.
// - Prewarning and shutdown temperature flags; shutdown turns bridges off.
// - After overtemperature, bridges stay off until prewarning has cleared.
// - Overcurrent confirmed by three retries before switching off.
// - Confirmed short turns both bridges off and sets the per-coil flag.
// - Restart after short only by disabling then re-enabling the driver.
// - Open-load flag per coil when coil current cannot be reached.
// - Open-load flags are informational and never touch the bridges.
// - By default the status pin shows that the driver cannot run normally.
// - Index configuration makes the status pin show counter zero position.
// - Counter increments when direction low, decrements when high, by step width.
// - Index active once per electrical period, at the counter zero point.
module sgf_step_fault_core
   import sgf_pkg::*;
#(
   parameter int SHORT_QUIET_CYC = SHORT_QUIET_US * CLK_MHZ
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   input  wire logic        stepIn,
   input  wire logic        dirIn,
   input  wire logic        tempPreWarnIn,
   input  wire logic        tempShutdownIn,
   input  wire logic [3:0]  shortDetIn,
   input  wire logic [1:0]  openLoadIn,
   output logic             bridgeEnable,
   output logic             stepOut,
   output logic             stepDirOut,
   output logic      [9:0]  msPosition,
   output logic             diagOut,
   output logic             irq
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [9:0]       rawIn;
   logic [9:0]       syncIn;
   logic             stepS;
   logic             dirS;
   logic             preWarnS;
   logic             shutdownS;
   logic [3:0]       shortS;
   logic [1:0]       openLoadS;

   sgf_cfg_type      cfg_r;
   logic [23:0]      velocity_r;
   logic [IRQ_W-1:0] irqEnable_r;
   logic [IRQ_W-1:0] irqStatus_r;
   logic [IRQ_W-1:0] irqStatusNxt;
   logic [IRQ_W-1:0] irqEvent;
   logic [IRQ_W-1:0] irqClear;

   logic             intStep;
   logic             intDir;
   logic             velActive;
   logic             stepPrev_r;
   logic             extStepEdge;
   logic             doStep;
   logic             doDir;
   logic [3:0]       resClamped;
   logic [9:0]       stepWidth;
   logic [9:0]       position_r;
   logic [9:0]       positionNxt;
   logic [19:0]      intervalCnt_r;
   logic [19:0]      interval_r;
   logic             stepToggle_r;

   logic             overTemp_r;
   logic             preWarnPrev_r;
   logic [1:0]       openLoadPrev_r;
   logic             shortLatched_r;
   logic [3:0]       shortFlag_r;
   logic [1:0]       retryCnt_r;
   logic [7:0]       pauseCnt_r;
   logic [31:0]      quietCnt_r;
   logic             pausing;
   logic             shortHit;
   logic             shortConfirm;
   logic             overTempSet;
   logic             bridgeDrive;
   logic             driverFault;
   logic             diagNxt;
   sgf_fault_type    faultStatus;

   logic             wrConfig;
   logic             wrVelocity;
   logic             wrIrqClear;
   logic             wrIrqEnable;
   logic [31:0]      rdMux;

   // ------------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------------
   assign rawIn = {openLoadIn, shortDetIn, tempShutdownIn, tempPreWarnIn, dirIn, stepIn};

   sgf_sync #(
      .WIDTH   (10)
   ) u_sync (
      .core_clk(core_clk),
      .rst     (rst),
      .asyncIn (rawIn),
      .syncOut (syncIn)
   );

   assign stepS     = syncIn[0];
   assign dirS      = syncIn[1];
   assign preWarnS  = syncIn[2];
   assign shutdownS = syncIn[3];
   assign shortS    = syncIn[7:4];
   assign openLoadS = syncIn[9:8];

   // ------------------------------------------------------------------
   // Register port decode
   // ------------------------------------------------------------------
   assign wrConfig    = regWr && (regAddr == REG_GLOBAL_CONFIG);
   assign wrVelocity  = regWr && (regAddr == REG_VELOCITY);
   assign wrIrqClear  = regWr && (regAddr == REG_IRQ_CLEAR);
   assign wrIrqEnable = regWr && (regAddr == REG_IRQ_ENABLE);
   assign irqClear    = wrIrqClear ? regWrData[IRQ_W-1:0] : '0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_r       <= CFG_RESET;
         velocity_r  <= VELOCITY_RESET;
         irqEnable_r <= '0;
      end else begin
         if (wrConfig) begin
            cfg_r <= sgf_cfg_type'(regWrData[6:0]);
         end
         if (wrVelocity) begin
            velocity_r <= regWrData[23:0];
         end
         if (wrIrqEnable) begin
            irqEnable_r <= regWrData[IRQ_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Step source selection
   // ------------------------------------------------------------------
   sgf_velocity_gen u_velgen (
      .core_clk (core_clk),
      .rst      (rst),
      .velocity (velocity_r),
      .stepPulse(intStep),
      .stepDir  (intDir),
      .active   (velActive)
   );

   assign extStepEdge = stepS && !stepPrev_r;
   // External pins only take over when the internal generator is idle
   assign doStep      = cfg_r.drvEnable && (velActive ? intStep : extStepEdge);
   assign doDir       = velActive ? intDir : dirS;

   // ------------------------------------------------------------------
   // Microstep position counter
   // ------------------------------------------------------------------
   assign resClamped  = (cfg_r.resSel > RES_SEL_MAX) ? RES_SEL_MAX : cfg_r.resSel;
   assign stepWidth   = 10'(11'h001 << resClamped);
   // Ten bits wrap naturally at one electrical revolution
   assign positionNxt = doDir ? (position_r - stepWidth)
                              : (position_r + stepWidth);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stepPrev_r   <= 1'b0;
         position_r   <= 10'h000;
         stepToggle_r <= 1'b0;
         stepOut      <= 1'b0;
         stepDirOut   <= 1'b0;
      end else begin
         stepPrev_r <= stepS;
         stepOut    <= doStep;
         stepDirOut <= doDir;
         if (doStep) begin
            position_r   <= positionNxt;
            stepToggle_r <= !stepToggle_r;
         end
      end
   end

   assign msPosition = position_r;

   // ------------------------------------------------------------------
   // Step interval measurement
   // ------------------------------------------------------------------
   // Saturates so a stopped motor reads as the slowest interval
   always_ff @(posedge core_clk) begin
      if (rst) begin
         intervalCnt_r <= 20'h0_0000;
         interval_r    <= INTERVAL_MAX;
      end else if (doStep) begin
         interval_r    <= intervalCnt_r;
         intervalCnt_r <= 20'h0_0001;
      end else if (intervalCnt_r != INTERVAL_MAX) begin
         intervalCnt_r <= intervalCnt_r + 20'h0_0001;
      end else begin
         interval_r    <= INTERVAL_MAX;
      end
   end

   // ------------------------------------------------------------------
   // Overtemperature
   // ------------------------------------------------------------------
   assign overTempSet = shutdownS && !overTemp_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         overTemp_r <= 1'b0;
      end else if (shutdownS) begin
         overTemp_r <= 1'b1;
      end else if (!preWarnS) begin
         overTemp_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Short protection with retries
   // ------------------------------------------------------------------
   assign pausing      = (pauseCnt_r != 8'h00);
   // A detector only means something while the bridges really drive
   assign shortHit     = (|shortS) && bridgeDrive;
   assign shortConfirm = shortHit && (retryCnt_r == SHORT_RETRIES);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         shortLatched_r <= 1'b0;
         shortFlag_r    <= 4'h0;
         retryCnt_r     <= 2'h0;
         pauseCnt_r     <= 8'h00;
         quietCnt_r     <= 32'h0000_0000;
      end else if (!cfg_r.drvEnable) begin
         shortLatched_r <= 1'b0;
         shortFlag_r    <= 4'h0;
         retryCnt_r     <= 2'h0;
         pauseCnt_r     <= 8'h00;
         quietCnt_r     <= 32'h0000_0000;
      end else if (shortConfirm) begin
         shortLatched_r <= 1'b1;
         shortFlag_r    <= shortFlag_r | shortS;
      end else if (shortHit) begin
         retryCnt_r     <= retryCnt_r + 2'h1;
         pauseCnt_r     <= RETRY_BLANK_CYC;
         quietCnt_r     <= 32'h0000_0000;
      end else begin
         if (pausing) begin
            pauseCnt_r <= pauseCnt_r - 8'h01;
         end
         // Long quiet spell forgets isolated spurious hits
         if (quietCnt_r == 32'(SHORT_QUIET_CYC)) begin
            retryCnt_r <= 2'h0;
         end else begin
            quietCnt_r <= quietCnt_r + 32'h0000_0001;
         end
      end
   end

   // ------------------------------------------------------------------
   // Bridge control and status pin
   // ------------------------------------------------------------------
   // Open-load inputs deliberately absent here
   assign bridgeDrive = cfg_r.drvEnable && !shortLatched_r
                        && !overTemp_r
                        && !pausing;
   assign driverFault = overTemp_r || shortLatched_r || !cfg_r.drvEnable;

   always_comb begin
      if (cfg_r.diagStep) begin
         diagNxt = stepToggle_r;
      end else if (cfg_r.diagIndex) begin
         diagNxt = (position_r == 10'h000);
      end else begin
         diagNxt = driverFault;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bridgeEnable <= 1'b0;
         diagOut      <= 1'b0;
      end else begin
         bridgeEnable <= bridgeDrive;
         diagOut      <= diagNxt;
      end
   end

   // ------------------------------------------------------------------
   // Fault status and interrupts
   // ------------------------------------------------------------------
   assign faultStatus.bridgeOn  = bridgeEnable;
   assign faultStatus.openLoad  = openLoadS;
   assign faultStatus.shortFlag = shortFlag_r;
   assign faultStatus.overTemp  = overTemp_r;
   assign faultStatus.preWarn   = preWarnS;

   always_comb begin
      irqEvent               = '0;
      irqEvent[IRQ_PREWARN]  = preWarnS && !preWarnPrev_r;
      irqEvent[IRQ_OVERTEMP] = overTempSet;
      irqEvent[IRQ_SHORT]    = shortConfirm && cfg_r.drvEnable;
      irqEvent[IRQ_OPEN_A]   = openLoadS[0] && !openLoadPrev_r[0];
      irqEvent[IRQ_OPEN_B]   = openLoadS[1] && !openLoadPrev_r[1];
      irqEvent[IRQ_INDEX]    = doStep && (positionNxt == 10'h000);
   end

   // New events win over a clear in the same cycle
   assign irqStatusNxt = (irqStatus_r & ~irqClear) | irqEvent;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqStatus_r    <= '0;
         preWarnPrev_r  <= 1'b0;
         openLoadPrev_r <= 2'b00;
         irq            <= 1'b0;
      end else begin
         irqStatus_r    <= irqStatusNxt;
         preWarnPrev_r  <= preWarnS;
         openLoadPrev_r <= openLoadS;
         irq            <= |(irqStatusNxt & irqEnable_r);
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   always_comb begin
      case (regAddr)
         REG_GLOBAL_CONFIG:  rdMux = {25'h000_0000, cfg_r};
         REG_VELOCITY:       rdMux = {8'h00, velocity_r};
         REG_STEP_INTERVAL:  rdMux = {12'h000, interval_r};
         REG_MSTEP_POSITION: rdMux = {22'h00_0000, position_r};
         REG_FAULT_STATUS:   rdMux = {23'h00_0000, faultStatus};
         REG_IRQ_STATUS:     rdMux = {26'h000_0000, irqStatus_r};
         REG_IRQ_ENABLE:     rdMux = {26'h000_0000, irqEnable_r};
         default:            rdMux = 32'h0000_0000;
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (rst || !regRd) begin
         regRdData <= 32'h0000_0000;
      end else begin
         regRdData <= rdMux;
      end
   end

endmodule

/* verilog/sgf_sync.sv */
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are slow levels; each bit is caught on its own.
`timescale 1ns/1ps

module sgf_sync
   import sgf_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_r;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (rst) begin
               stage1_r[i] <= 1'b0;
               syncOut[i]  <= 1'b0;
            end else begin
               stage1_r[i] <= asyncIn[i];
               syncOut[i]  <= stage1_r[i];
            end
         end
      end
   endgenerate

endmodule

/* verilog/sgf_velocity_gen.sv */
// Internal constant-rate step pulse generator.
// Assumes a signed 24-bit velocity word from the register file.
`timescale 1ns/1ps

module sgf_velocity_gen
   import sgf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [23:0] velocity,
   output logic             stepPulse,
   output logic             stepDir,
   output logic             active
);

   logic [23:0] accum_r;
   logic [23:0] accumNxt;
   logic [23:0] magnitude;
   logic        carry;

   // Phase accumulator: carry rate is magnitude * fclk / 2^24, no ramp
   assign magnitude          = velocity[23] ? 24'(-velocity) : velocity;
   assign {carry, accumNxt}  = {1'b0, accum_r} + {1'b0, magnitude};
   assign active             = (velocity != VELOCITY_RESET);
   assign stepDir            = velocity[23];

   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         accum_r   <= 24'h00_0000;
         stepPulse <= 1'b0;
      end else begin
         accum_r   <= accumNxt;
         stepPulse <= carry;
      end
   end

endmodule
